// >>> src/wbc_pkg.sv
// Behaviour
// - Watchdog control byte must have even parity
// - Bit 6 turns watchdog off in stop
// - Bit 5 selects time-out or window watchdog
// - Bit 4 starts watchdog after bus wake
// - Reserved bits are read-only, read zero
// - Period code 000..101 gives 10..500 ms
// - Flash bit disables LIN slope control
// - Low-slope bit selects 10.4 kBaud mode
// - Bus bit 5 enables LIN transmit time-out
// - LIN mode field bits 4:3, hardware updatable
// - CAN mode field bits 1:0, hardware updatable
// - LIN option writes act at chip-select rise
// - Fail-safe reloads bus and wake registers
// - Peak bit 5 selects low or high threshold
// - Peak bit writable in init and normal only
// - Stop-mode peak write raises no failure
// - Watchdog register reset and restart values
// - Bus register resets to 0010 0000
// - Peak register reset zero, restart keeps bit
// - Write response returns previous register contents
package wbc_pkg;

  localparam logic [6:0] WBC_ADDR_WDOG = 7'h03;
  localparam logic [6:0] WBC_ADDR_BUS = 7'h04;
  localparam logic [6:0] WBC_ADDR_PEAK = 7'h05;

  localparam logic [7:0] WBC_WDOG_POR = 8'h14;
  localparam logic [7:0] WBC_BUS_POR = 8'h20;
  localparam logic [7:0] WBC_PEAK_POR = 8'h00;

  localparam logic [7:0] WBC_WDOG_RESTART_KEEP = 8'hb0;
  localparam logic [7:0] WBC_WDOG_RESTART_VAL = 8'h04;
  localparam logic [7:0] WBC_PEAK_RESTART_KEEP = 8'h20;
  localparam logic [7:0] WBC_BUS_FAILSAFE_KEEP = 8'he0;
  localparam logic [7:0] WBC_BUS_FAILSAFE_VAL = 8'h09;

  localparam logic [7:0] WBC_WDOG_WMASK = 8'hf7;
  localparam logic [7:0] WBC_BUS_WMASK = 8'hfb;
  localparam logic [7:0] WBC_PEAK_WMASK = 8'h20;

  localparam int WBC_PERIOD_LSB = 0;
  localparam int WBC_STOP_OFF_POS = 6;
  localparam int WBC_LIN_MODE_LSB = 3;
  localparam int WBC_CAN_MODE_LSB = 0;
  localparam int WBC_RW_POS = 7;
  localparam int WBC_CHECKSUM_POS = 7;
  localparam int WBC_WINDOW_POS = 5;
  localparam int WBC_WAKE_START_POS = 4;
  localparam int WBC_FLASH_POS = 7;
  localparam int WBC_LOW_SLOPE_POS = 6;
  localparam int WBC_TXD_TO_POS = 5;
  localparam int WBC_PEAK_POS = 5;

  localparam logic [2:0] WBC_PERIOD_MAX_CODE = 3'h5;
  localparam logic [4:0] WBC_FRAME_BITS = 5'h10;
  localparam logic [4:0] WBC_ADDR_BITS = 5'h08;

  localparam logic [1:0] WBC_MODE_INIT = 2'h0;
  localparam logic [1:0] WBC_MODE_NORMAL = 2'h1;
  localparam logic [1:0] WBC_MODE_STOP = 2'h2;
  localparam logic [1:0] WBC_MODE_OTHER = 2'h3;

  typedef enum logic {WBC_IDLE, WBC_ACTIVE} wbc_spi_state_t;

  typedef struct packed {
    logic checksum;
    logic stop_mode_wdog_off_bit0;
    logic window_type_select;
    logic wdog_start_after_bus_wake;
    logic [2:0] wdog_period_code;
    logic cfg_valid;
  } wbc_wdog_cfg_t;

  typedef struct packed {
    logic lin_flash_mode;
    logic lin_low_slope_select;
    logic lin_transmit_timeout_enable;
    logic [1:0] lin_channel_mode;
    logic [1:0] can_mode;
  } wbc_bus_cfg_t;

  typedef struct packed {
    logic stop_off_load;
    logic stop_off_val;
    logic period_load;
    logic [2:0] period_val;
    logic lin_mode_load;
    logic [1:0] lin_mode_val;
    logic can_mode_load;
    logic [1:0] can_mode_val;
  } wbc_hw_update_t;

  typedef struct packed {
    logic [1:0] cs_sync;
    logic [2:0] sck_sync;
    logic [1:0] sdi_sync;
    logic cs_prev;
    wbc_spi_state_t st;
    logic [4:0] bit_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic sdo_bit;
    logic frame_fail;
    logic wake_reload;
    logic [7:0] wdog;
    logic [7:0] bus;
    logic [7:0] peak;
  } wbc_state_t;

endpackage

// >>> src/wbc_regs.sv
`timescale 1ns/1ns
module wbc_regs
  import wbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic failsafe_entry,
  input wire logic [1:0] sbc_mode,
  input wire wbc_hw_update_t hw_update,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  output wbc_wdog_cfg_t wdog_cfg,
  output wbc_bus_cfg_t bus_cfg,
  output logic active_peak_threshold_select,
  output logic spi_fail,
  output logic ext_wake_reload
);

  wbc_state_t state_reg;
  wbc_state_t state_next;

  function automatic logic [7:0] read_reg(input logic [6:0] addr, input wbc_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      WBC_ADDR_WDOG: v = s.wdog & WBC_WDOG_WMASK;
      WBC_ADDR_BUS: v = s.bus & WBC_BUS_WMASK;
      WBC_ADDR_PEAK: v = s.peak & WBC_PEAK_WMASK;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Only the written bits move; reserved positions stay zero
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                       input logic [7:0] wmask);
    return (old & ~wmask) | (data & wmask);
  endfunction

  always_comb begin
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic [6:0] addr;
    logic [7:0] data;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    addr = 7'h00;
    data = 8'h00;
    state_next = state_reg;
    state_next.wake_reload = 1'b0;

    // Pins are asynchronous to clk; stage 0 feeds only stage 1
    state_next.cs_sync = {state_reg.cs_sync[0], chip_select_n};
    state_next.sck_sync = {state_reg.sck_sync[1:0], sclk};
    state_next.sdi_sync = {state_reg.sdi_sync[0], sdi};
    state_next.cs_prev = state_reg.cs_sync[1];
    sck_rise = state_reg.sck_sync[1] & ~state_reg.sck_sync[2];
    sck_fall = ~state_reg.sck_sync[1] & state_reg.sck_sync[2];
    cs_fall = ~state_reg.cs_sync[1] & state_reg.cs_prev;
    cs_rise = state_reg.cs_sync[1] & ~state_reg.cs_prev;

    case (state_reg.st)
      WBC_IDLE: begin
        if (cs_fall) begin
          state_next.st = WBC_ACTIVE;
          state_next.bit_cnt = 5'h00;
          state_next.tx = {8'h00, 7'h00, state_reg.frame_fail};
          state_next.sdo_bit = state_reg.frame_fail;
        end
      end
      WBC_ACTIVE: begin
        if (cs_rise) begin
          state_next.st = WBC_IDLE;
          // A frame of any other length is dropped and flagged
          state_next.frame_fail = (state_reg.bit_cnt != WBC_FRAME_BITS);
          addr = state_reg.rx[6:0];
          data = state_reg.rx[15:8];
          if (state_reg.bit_cnt == WBC_FRAME_BITS && state_reg.rx[WBC_RW_POS]) begin
            case (addr)
              WBC_ADDR_WDOG: begin
                state_next.wdog = merge(state_reg.wdog, data, WBC_WDOG_WMASK);
              end
              WBC_ADDR_BUS: begin
                // Options drive the one LIN channel of bus_cfg from this edge on
                state_next.bus = merge(state_reg.bus, data, WBC_BUS_WMASK);
              end
              WBC_ADDR_PEAK: begin
                // Stop mode: silently ignored, no failure flag
                if (sbc_mode == WBC_MODE_INIT || sbc_mode == WBC_MODE_NORMAL) begin
                  state_next.peak = merge(state_reg.peak, data, WBC_PEAK_WMASK);
                end
              end
              default: begin
                state_next.wdog = state_reg.wdog;
              end
            endcase
          end
        end else begin
          if (sck_rise) begin
            state_next.rx = {state_reg.sdi_sync[1], state_reg.rx[15:1]};
            if (state_reg.bit_cnt != 5'h1f) begin
              state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
            end
            // Address complete: queue the contents held before this frame
            if (state_reg.bit_cnt + 5'h01 == WBC_ADDR_BITS) begin
              // Seven bits in so far, sitting in the top of the shifter
              state_next.tx[8:1] = read_reg(state_reg.rx[15:9], state_reg);
            end
          end
          if (sck_fall) begin
            state_next.tx = {1'b0, state_reg.tx[15:1]};
            state_next.sdo_bit = state_reg.tx[1];
          end
        end
      end
      default: begin
        state_next.st = WBC_IDLE;
      end
    endcase

    // Hardware updates win over a write landing in the same cycle
    if (hw_update.stop_off_load) begin
      state_next.wdog[WBC_STOP_OFF_POS] = hw_update.stop_off_val;
    end
    if (hw_update.period_load) begin
      state_next.wdog[WBC_PERIOD_LSB +: 3] = hw_update.period_val;
    end
    if (hw_update.lin_mode_load) begin
      state_next.bus[WBC_LIN_MODE_LSB +: 2] = hw_update.lin_mode_val;
    end
    if (hw_update.can_mode_load) begin
      state_next.bus[WBC_CAN_MODE_LSB +: 2] = hw_update.can_mode_val;
    end

    if (failsafe_entry) begin
      state_next.bus = (state_reg.bus & WBC_BUS_FAILSAFE_KEEP) | WBC_BUS_FAILSAFE_VAL;
      state_next.wake_reload = 1'b1;
    end
    if (restart) begin
      state_next.wdog = (state_reg.wdog & WBC_WDOG_RESTART_KEEP) | WBC_WDOG_RESTART_VAL;
      state_next.peak = state_reg.peak & WBC_PEAK_RESTART_KEEP;
    end
    if (soft_reset) begin
      state_next.wdog = WBC_WDOG_POR;
      state_next.bus = WBC_BUS_POR;
      state_next.peak = WBC_PEAK_POR;
    end

    // Pin is already released by the enable; clearing waits for the synchroniser
    if (state_reg.cs_sync[1]) begin
      state_next.sdo_bit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.cs_sync <= 2'h3;
      state_reg.cs_prev <= 1'b1;
      state_reg.st <= WBC_IDLE;
      state_reg.wdog <= WBC_WDOG_POR;
      state_reg.bus <= WBC_BUS_POR;
      state_reg.peak <= WBC_PEAK_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sdo = state_reg.sdo_bit;
  assign sdo_oe_n = chip_select_n;
  assign wdog_cfg.checksum = state_reg.wdog[WBC_CHECKSUM_POS];
  assign wdog_cfg.stop_mode_wdog_off_bit0 = state_reg.wdog[WBC_STOP_OFF_POS];
  assign wdog_cfg.window_type_select = state_reg.wdog[WBC_WINDOW_POS];
  assign wdog_cfg.wdog_start_after_bus_wake = state_reg.wdog[WBC_WAKE_START_POS];
  assign wdog_cfg.wdog_period_code = state_reg.wdog[WBC_PERIOD_LSB +: 3];
  // Parity odd or reserved period code: the engine must not accept it
  assign wdog_cfg.cfg_valid = ~(^(state_reg.wdog & WBC_WDOG_WMASK))
      && (state_reg.wdog[WBC_PERIOD_LSB +: 3] <= WBC_PERIOD_MAX_CODE);
  assign bus_cfg.lin_flash_mode = state_reg.bus[WBC_FLASH_POS];
  assign bus_cfg.lin_low_slope_select = state_reg.bus[WBC_LOW_SLOPE_POS];
  assign bus_cfg.lin_transmit_timeout_enable = state_reg.bus[WBC_TXD_TO_POS];
  assign bus_cfg.lin_channel_mode = state_reg.bus[WBC_LIN_MODE_LSB +: 2];
  assign bus_cfg.can_mode = state_reg.bus[WBC_CAN_MODE_LSB +: 2];
  assign active_peak_threshold_select = state_reg.peak[WBC_PEAK_POS];
  assign spi_fail = state_reg.frame_fail;
  assign ext_wake_reload = state_reg.wake_reload;

endmodule

// >>> verif/wbc_regs_asserts.sv
`timescale 1ns/1ns
module wbc_regs_asserts
  import wbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic failsafe_entry,
  input wire logic [1:0] sbc_mode,
  input wire wbc_hw_update_t hw_update,
  input wire logic chip_select_n,
  input wire wbc_wdog_cfg_t wdog_cfg,
  input wire wbc_bus_cfg_t bus_cfg,
  input wire logic active_peak_threshold_select,
  input wire logic ext_wake_reload
);
  wire logic apt = active_peak_threshold_select;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_soft; soft_reset |=> wdog_cfg == 8'h19 && bus_cfg == 7'h10 && !apt; endproperty
  a_soft: assert property (p_soft) else $error("soft reset values");
  property p_valid; wdog_cfg[0] == (!(^wdog_cfg[7:1]) && wdog_cfg[3:1] <= 3'h5); endproperty
  a_valid: assert property (p_valid) else $error("cfg valid flag");
  property p_stop; sbc_mode[1] && !soft_reset |=> $stable(apt); endproperty
  a_stop: assert property (p_stop) else $error("peak changed in stop");
  property p_rwd; restart && !soft_reset |=> !wdog_cfg[6] && wdog_cfg[3:1] == 3'h4 &&
    $stable({wdog_cfg[7], wdog_cfg[5:4]}); endproperty
  a_rwd: assert property (p_rwd) else $error("restart wdog value");
  property p_rpk; restart && !soft_reset |=> $stable(apt); endproperty
  a_rpk: assert property (p_rpk) else $error("restart peak value");
  property p_wake; ext_wake_reload == $past(failsafe_entry); endproperty
  a_wake: assert property (p_wake) else $error("wake reload pulse");
  // Flash, slope and time-out bits survive the reload
  property p_fs; failsafe_entry && !soft_reset |=> bus_cfg[3:0] == 4'h5 &&
    $stable(bus_cfg[6:4]); endproperty
  a_fs: assert property (p_fs) else $error("failsafe bus value");
  // Gap is at least 4 clk, so low now and 4 ago means no commit pending
  property p_quiet; !chip_select_n && !$past(chip_select_n, 4) && !failsafe_entry &&
    !soft_reset && !hw_update.lin_mode_load && !hw_update.can_mode_load |=>
    $stable(bus_cfg); endproperty
  a_quiet: assert property (p_quiet) else $error("bus changed mid frame");
  property p_hwl; hw_update.lin_mode_load && !failsafe_entry && !soft_reset |=>
    bus_cfg.lin_channel_mode == $past(hw_update.lin_mode_val); endproperty
  a_hwl: assert property (p_hwl) else $error("hardware lin mode load");
  property p_hwc; hw_update.can_mode_load && !failsafe_entry && !soft_reset |=>
    bus_cfg.can_mode == $past(hw_update.can_mode_val); endproperty
  a_hwc: assert property (p_hwc) else $error("hardware can mode load");
endmodule
bind wbc_regs wbc_regs_asserts wbc_regs_asserts_i (.clk, .reset, .soft_reset, .restart,
  .failsafe_entry, .sbc_mode, .hw_update, .chip_select_n, .wdog_cfg, .bus_cfg,
  .active_peak_threshold_select, .ext_wake_reload);

// >>> verif/wbc_host.sv
`timescale 1ns/1ns
module wbc_host (
  input wire logic clk,
  input wire logic sdo,
  output logic chip_select_n,
  output logic sclk,
  output logic sdi
);
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Mode 0, LSB first; sclk idles low, sdi inverted when idle so stale data never looks valid
  task automatic xfer(input logic [15:0] f, input int n, input int hp, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk) chip_select_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi <= f[i];
      repeat (hp) @(posedge clk);
      sclk <= 1'b1;
      r[i] = sdo;
      repeat (hp) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (hp) @(posedge clk);
    chip_select_n <= 1'b1;
    sdi <= ~sdi;
    repeat (8) @(posedge clk);
  endtask
endmodule

// >>> verif/wbc_regs_tb_top.sv
`timescale 1ns/1ns
module wbc_regs_tb_top;
  import wbc_pkg::*;
  logic clk, reset, soft_reset, restart, failsafe_entry, fl;
  logic [1:0] sbc_mode;
  logic chip_select_n, sclk, sdi, sdo, sdo_oe_n, spi_fail, ext_wake_reload, apt;
  logic [15:0] r;
  wbc_wdog_cfg_t wdog_cfg;
  wbc_bus_cfg_t bus_cfg;
  wbc_hw_update_t hw;
  int err_count = 0, num_checks = 0, seed = 32'ha78b;
  int m[8];
  wbc_regs wbc_regs_i (.clk, .reset, .soft_reset, .restart, .failsafe_entry, .sbc_mode,
    .hw_update(hw), .chip_select_n, .sclk, .sdi, .sdo, .sdo_oe_n, .wdog_cfg, .bus_cfg,
    .active_peak_threshold_select(apt), .spi_fail, .ext_wake_reload);
  wbc_host wbc_host_i (.clk, .sdo, .chip_select_n, .sclk, .sdi);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic outs;
    logic [7:0] w;
    w = m[3][7:0];
    chk({8'h00, wdog_cfg}, {8'h00, w[7:4], w[2:0], ~^w && w[2:0] <= 3'h5});
    chk({9'h000, bus_cfg}, {9'h000, m[4][7:3], m[4][1:0]});
    chk({15'h0000, apt}, {15'h0000, m[5][5]});
    chk({15'h0000, spi_fail}, {15'h0000, fl});
    chk({15'h0000, sdo_oe_n}, 16'h0001);
  endtask
  task automatic acc(input logic [6:0] a, input logic wr, input logic [7:0] d, input int n);
    logic [7:0] e;
    e = (a inside {[3:5]}) ? m[a][7:0] : 8'h00;
    wbc_host_i.xfer({d, wr, a}, n, 4 + ($random(seed) & 3), r);
    if (n == 16) chk(r, {e, 7'h00, fl});
    fl = (n != 16);
    if (n == 16 && wr && a == 7'h03) m[3] = d & 8'hf7;
    if (n == 16 && wr && a == 7'h04) m[4] = d & 8'hfb;
    if (n == 16 && wr && a == 7'h05 && !sbc_mode[1]) m[5] = d & 8'h20;
    outs();
  endtask
  task automatic ev(input int k);
    wbc_hw_update_t h;
    h = (k == 3) ? 13'($random(seed)) : 13'h0000;
    @(posedge clk);
    soft_reset <= (k == 0);
    restart <= (k == 1);
    failsafe_entry <= (k == 2);
    hw <= h;
    @(posedge clk);
    {soft_reset, restart, failsafe_entry} <= 3'h0;
    hw <= '0;
    #1;
    chk({15'h0000, ext_wake_reload}, {15'h0000, k == 2});
    @(posedge clk);
    #1;
    if (k == 0) m = '{0, 0, 0, 'h14, 'h20, 0, 0, 0};
    if (k == 1) m[3] = (m[3] & 'hb0) | 'h04;
    if (k == 2) m[4] = (m[4] & 'he0) | 'h09;
    if (h.stop_off_load) m[3][6] = h.stop_off_val;
    if (h.period_load) m[3][2:0] = h.period_val;
    if (h.lin_mode_load) m[4][4:3] = h.lin_mode_val;
    if (h.can_mode_load) m[4][1:0] = h.can_mode_val;
    outs();
  endtask
  initial begin
    reset = 1'b1;
    {soft_reset, restart, failsafe_entry} = 3'h0;
    sbc_mode = 2'h0;
    hw = '0;
    fl = 1'b0;
    m = '{0, 0, 0, 'h14, 'h20, 0, 0, 0};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    outs();
    for (int i = 3; i < 7; i++) acc(i[6:0], 1'b0, 8'h00, 16);
    for (int c = 0; c < 8; c++) begin
      acc(7'h03, 1'b1, 8'(c * 9), 16);
      acc(7'h04, 1'b1, 8'(c * 9), 16);
    end
    for (int i = 0; i < 40; i++) begin
      logic [7:0] d;
      d = 8'($random(seed));
      // Writes with d[0] set carry a correct checksum; the rest keep a random bit 7
      if (d[0]) d[7] = ^(d[6:0] & 7'h77);
      sbc_mode <= 2'($random(seed));
      acc(7'(3 + ($random(seed) & 3)), 1'b1, d, 16);
    end
    acc(7'h04, 1'b1, 8'hff, 15);
    acc(7'h04, 1'b0, 8'h00, 16);
    sbc_mode <= 2'h1;
    acc(7'h05, 1'b1, 8'hff, 16);
    acc(7'h03, 1'b1, 8'hff, 16);
    for (int i = 0; i < 6; i++) ev(3);
    acc(7'h03, 1'b0, 8'h00, 16);
    acc(7'h04, 1'b0, 8'h00, 16);
    ev(1);
    ev(2);
    ev(0);
    acc(7'h05, 1'b0, 8'h00, 16);
    complete_run();
  end
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
endmodule
